// File: bench/oms_aux_model.sv
// Purpose: External control contacts seen by the supervisor
// Assumes: Levels are set by the bench between mode requests
// Notes:   Host link traffic is driven by the bench over APB
`timescale 1ns/1ps
`default_nettype none
module oms_aux_model (
    input  wire logic       pclk,
    input  wire logic [1:0] want,
    output logic      [1:0] aux_mode
);
    // Contacts change on an edge and then hold as a steady level
    always_ff @(posedge pclk) begin
        aux_mode <= want;
    end
endmodule : oms_aux_model
`default_nettype wire

// File: bench/oms_supervisor_props.sv
// Purpose: Port assertions for the mode supervisor
// Assumes: One pclk domain, presetn async active low
// Notes:   Status lags state a cycle, so causes are held first
`timescale 1ns/1ps
`default_nettype none
module oms_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       err_cond,
    input wire logic       warn_cond,
    input wire logic       measuring,
    input wire logic [1:0] top_mode,
    input wire logic [1:0] sub_mode,
    input wire logic [1:0] owner,
    input wire logic [1:0] disp_kind,
    input wire logic [2:0] msg_code,
    input wire logic       relay_warn,
    input wire logic       relay_err,
    input wire logic       relay_alarm,
    input wire logic       relay_maint,
    input wire logic       loop_force_2ma
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Held causes, long enough to outlast the status lag
    sequence s_fault; top_mode == 2'h2 ##1 top_mode == 2'h2; endsequence
    sequence s_err; (err_cond && measuring) [*3]; endsequence
    sequence s_warn; (warn_cond && !err_cond && measuring) [*3]; endsequence
    a_top_legal: assert property (top_mode != 2'h3)
        else $error("top mode outside the three states");
    a_meas_flag: assert property (!measuring && !$past(measuring)
        |-> sub_mode == 2'h0 && owner == 2'h0)
        else $error("sub mode held outside measuring");
    a_fault_relays: assert property (s_fault |-> relay_alarm
        && !relay_warn && !relay_err && !measuring && loop_force_2ma)
        else $error("fault relays wrong");
    a_fault_off: assert property (s_fault |-> disp_kind == 2'h3
        && msg_code[2:1] == 2'h3) else $error("fault display not off");
    a_err_relays: assert property (s_err |-> !relay_warn &&
        !relay_err && disp_kind == 2'h2 && loop_force_2ma &&
        msg_code == 3'h5) else $error("error outputs wrong");
    a_warn_loop: assert property (s_warn |-> !relay_warn
        && !loop_force_2ma && (msg_code == 3'h3 || msg_code == 3'h4))
        else $error("warning outputs wrong");
    a_maint_rly: assert property (relay_maint |-> sub_mode == 2'h3
        || $past(sub_mode) == 2'h3) else $error("maint relay stray");
    a_lock_owner: assert property ((measuring && sub_mode != 2'h0)
        [*2] |-> owner != 2'h0) else $error("sub mode with no owner");
endmodule : oms_chk
bind oms_supervisor oms_chk oms_chk_inst (.*);
`default_nettype wire

// File: bench/operating_mode_supervisor_tb_top.sv
// Purpose: Self-checking bench for the mode supervisor
// Assumes: Short fault hour (4 ticks) and short ramp steps
// Notes:   Port checks go through register reads over APB, except wait_top on top_mode
`timescale 1ns/1ps
`default_nettype none
module operating_mode_supervisor_tb_top;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, tick_1s = 1'h0, wdog_evt = 1'h0;
    logic        selftest_done = 1'h1, selftest_pass = 1'h1;
    logic        laser_temp_ok = 1'h1, severe_fail = 1'h0;
    logic        warn_cond = 1'h0, err_cond = 1'h0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] stab_fig = 16'h01F4, avg_conc = 16'h0, det_level = 16'h0400;
    logic [3:0]  fault_code = 4'h0;
    logic [1:0]  aux_want = 2'h0, aux_mode, top_mode;
    logic [63:0] exq[$];
    int          n_fail = 0, checked = 0, cyc_n = 0;

    oms_aux_model oms_aux_model_inst (.pclk(pclk), .want(aux_want),
        .aux_mode(aux_mode));
    oms_supervisor #(.FAULT_SECS(4), .RAMP_DIV(2)) oms_supervisor_inst (
        .*, .selftest_go(), .stab_out(), .laser_pwr(), .measuring(),
        .sub_mode(), .owner(), .cause_wdog(), .disp_kind(), .msg_code(),
        .fault_nature(), .disp_conc(), .disp_trans(), .trans_max(),
        .disp_upd(), .relay_warn(), .relay_err(), .relay_alarm(),
        .relay_maint(), .loop_force_2ma());

    always #4 pclk = ~pclk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task wrap_up;
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Request held until pready is seen high, then released
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        exq.push_back({m, v});
        apb(1'h0, a, 32'h0);
    endtask : rd

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // Bounded wait; running out counts as a failure
    task wait_top(input logic [1:0] tm);
        for (int i = 0; i < 3000 && top_mode !== tm; i++) @(posedge pclk);
        if (top_mode !== tm) n_fail++;
    endtask : wait_top

    // One request from host (h=1) or contacts, then judge STATUS
    task mode(input logic h, input logic [1:0] v, input logic [31:0] m,
              input logic [31:0] e);
        if (h) apb(1'h1, 8'h00, {$urandom} & 32'hFFFFFFF8 | v);
        else aux_want <= v;
        cyc(12);
        rd(8'h0C, m, e);
    endtask : mode

    task tick;
        tick_1s <= 1'h1;
        @(posedge pclk);
        tick_1s <= 1'h0;
        cyc(3);
    endtask : tick

    // Monitor: each completed read takes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'h1 && !pwrite && exq.size()) begin
            chk(prdata & exq[0][63:32], exq[0][31:0]);
            void'(exq.pop_front());
        end
    end

    // Hang guard
    always @(posedge pclk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h7FBED9ED));
        cyc(5);
        presetn <= 1'h1;
        avg_conc <= 16'($urandom);
        cyc(20);
        rd(8'h0C, 32'h43, 32'h00);
        rd(8'h04, 32'h1F, 32'h0B);
        rd(8'h08, 32'hFFFF, 32'h0100);
        rd(8'h14, 32'hFFFFFFFF, 32'h0);
        stab_fig <= 16'h012C;
        cyc(40);
        rd(8'h0C, 32'hFF0003, 32'h0);
        laser_temp_ok <= 1'h0;
        stab_fig <= 16'h012B;
        cyc(20);
        rd(8'h0C, 32'h3, 32'h0);
        laser_temp_ok <= 1'h1;
        wait_top(2'h1);
        cyc(4);
        rd(8'h0C, 32'hFF00FF, 32'hFF0001);
        mode(1'h1, 2'h1, 32'h3F, 32'h15);
        mode(1'h0, 2'h3, 32'h3F, 32'h15);
        mode(1'h1, 2'h2, 32'h3F, 32'h15);
        mode(1'h0, 2'h0, 32'h3F, 32'h15);
        mode(1'h1, 2'h0, 32'h0F, 32'h01);
        mode(1'h0, 2'h2, 32'h3F, 32'h29);
        mode(1'h1, 2'h0, 32'h3F, 32'h29);
        mode(1'h0, 2'h0, 32'h0F, 32'h01);
        mode(1'h0, 2'h3, 32'h3F, 32'h2D);
        mode(1'h1, 2'h0, 32'h3F, 32'h2D);
        mode(1'h0, 2'h0, 32'h0F, 32'h01);
        warn_cond <= 1'h1;
        cyc(6);
        rd(8'h0C, 32'h183, 32'h081);
        err_cond <= 1'h1;
        cyc(6);
        rd(8'h0C, 32'h183, 32'h181);
        warn_cond <= 1'h0;
        err_cond <= 1'h0;
        det_level <= 16'h00FF;
        cyc(6);
        rd(8'h0C, 32'h203, 32'h201);
        det_level <= 16'h0100 | 16'($urandom);
        tick();
        rd(8'h10, 32'hFFFFFFFF, 32'h0);
        tick();
        rd(8'h10, 32'hFFFFFFFF, {det_level, avg_conc});
        apb(1'h1, 8'h00, 32'h4);
        cyc(5);
        rd(8'h0C, 32'h3, 32'h2);
        apb(1'h1, 8'h00, 32'h0);
        wait_top(2'h1);
        cyc(4);
        rd(8'h0C, 32'h43, 32'h01);
        fault_code <= 4'hA;
        severe_fail <= 1'h1;
        cyc(6);
        rd(8'h0C, 32'hF003, 32'hA002);
        severe_fail <= 1'h0;
        stab_fig <= 16'h01F4;
        fault_code <= 4'h5;
        repeat (3) tick();
        rd(8'h0C, 32'hF003, 32'hA002);
        tick();
        cyc(4);
        rd(8'h0C, 32'h43, 32'h40);
        presetn <= 1'h0;
        cyc(2);
        presetn <= 1'h1;
        cyc(4);
        rd(8'h0C, 32'h43, 32'h00);
        wdog_evt <= 1'h1;
        cyc(1);
        wdog_evt <= 1'h0;
        cyc(4);
        rd(8'h0C, 32'h43, 32'h40);
        cyc(4);
        wrap_up();
    end
endmodule : operating_mode_supervisor_tb_top
`default_nettype wire

// File: src/oms_defines.svh
// Purpose: Constants for the operating mode supervisor
// Assumes: One APB word per register, byte addresses
// Notes:   Figures in thousandths, fault time in timebase ticks, ramp step in clocks
`ifndef OMS_DEFINES_SVH
`define OMS_DEFINES_SVH
// Register byte offsets
`define OMS_CTRL_OFS     8'h00
`define OMS_CFG_OFS      8'h04
`define OMS_LOWTX_OFS    8'h08
`define OMS_STATUS_OFS   8'h0C
`define OMS_DISP_OFS     8'h10
// CTRL fields
`define OMS_CTRL_MODE_LO 0
`define OMS_CTRL_MODE_HI 1
`define OMS_CTRL_TEST    2
// CFG fields and reset value
`define OMS_CFG_RLY3     0
`define OMS_CFG_LOOP2    1
`define OMS_CFG_PER_LO   2
`define OMS_CFG_PER_HI   4
`define OMS_CFG_RST      5'h0B
// STATUS fields
`define OMS_ST_TOP       0
`define OMS_ST_SUB       2
`define OMS_ST_OWN       4
`define OMS_ST_CAUSE     6
`define OMS_ST_WARN      7
`define OMS_ST_ERR       8
`define OMS_ST_LOWTX     9
`define OMS_ST_FCODE     12
`define OMS_ST_LPWR      16
// Stability limit 0.3 in thousandths
`define OMS_STAB_LIMIT   16'h012C
// Fault restart: one hour of one-second ticks
`define OMS_FAULT_SECS   3600
// Clocks per laser power step during power-up
`define OMS_RAMP_DIV     250
`define OMS_LPWR_MAX     8'hFF
`define OMS_LOWTX_RST    16'h0100
`endif

// File: src/oms_pkg.sv
// Purpose: Types for the operating mode supervisor
// Assumes: Used through scoped names only
// Notes:   Encodings are the default ones, counted up from zero
package oms_pkg;
    typedef enum logic [1:0] {TOP_START, TOP_MEAS, TOP_FAULT} oms_top_t;
    typedef enum logic [2:0] {S_INIT, S_SELFTEST, S_WARM, S_RAMP, S_MEAS,
                              S_FAULT} oms_state_t;
    typedef enum logic [1:0] {SUB_NORMAL, SUB_ZERO, SUB_SPAN,
                              SUB_MAINT} oms_sub_t;
    typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_AUX} oms_own_t;
    typedef enum logic [1:0] {DISP_START, DISP_CONC, DISP_ERROR,
                              DISP_OFF} oms_disp_t;
    typedef enum logic [2:0] {MSG_NONE, MSG_POWER, MSG_WDOG, MSG_WARN,
                              MSG_LOWTX, MSG_ERR, MSG_FAULT,
                              MSG_TEST} oms_msg_t;
endpackage : oms_pkg

// File: src/oms_supervisor.sv
// Purpose: Operating mode supervisor of a gas analyser
// Assumes: Status inputs come from logic on pclk; aux_mode is a pin
// Notes:   Registers over APB; relay outputs high means energised
//
// Summary of operation
// - Always in exactly one of start-up, measuring or fault.
// - Init, self-test, start-up precede measuring; wait for laser temp.
// - Start-up reports power cause or supervision-restart cause.
// - Show falling stability figure; below 0.3 ramp laser up.
// - Measuring holds one of four sub-modes.
// - Sub-mode requested from host link or external control inputs.
// - From normal either channel switches mode and becomes owner.
// - In zero or maintenance only owner returns to normal.
// - Normal mode refreshes display and loop every 1 to 7 s.
// - Display shows averaged concentration and transmission figure.
// - Warning keeps measuring, opens warning relay, loop untouched.
// - Error shows error, opens both relays, optional 2 mA loop.
// - Maintenance keeps measuring and drives relay 3 if configured.
// - Severe failure enters fault, alarms, opens relays, optional 2 mA loop.
// - Fault shows instrument off and fault nature, no concentration.
// - After one hour in fault restart through start-up.
// - Relay or loop test from host puts device in sleep.
// - Low optical signal raises a low-transmission warning.
`include "oms_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module oms_supervisor #(
    parameter int          FAULT_SECS = `OMS_FAULT_SECS,
    parameter int          RAMP_DIV   = `OMS_RAMP_DIV,
    parameter logic [15:0] TRANS_MAX  = 16'hFFFF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  aux_mode,
    input  wire logic        tick_1s,
    input  wire logic        wdog_evt,
    input  wire logic        selftest_done,
    input  wire logic        selftest_pass,
    input  wire logic        laser_temp_ok,
    input  wire logic [15:0] stab_fig,
    input  wire logic        severe_fail,
    input  wire logic [3:0]  fault_code,
    input  wire logic        warn_cond,
    input  wire logic        err_cond,
    input  wire logic [15:0] avg_conc,
    input  wire logic [15:0] det_level,
    output logic             selftest_go,
    output logic [15:0]      stab_out,
    output logic [7:0]       laser_pwr,
    output logic             measuring,
    output logic [1:0]       top_mode,
    output logic [1:0]       sub_mode,
    output logic [1:0]       owner,
    output logic             cause_wdog,
    output logic [1:0]       disp_kind,
    output logic [2:0]       msg_code,
    output logic [3:0]       fault_nature,
    output logic [15:0]      disp_conc,
    output logic [15:0]      disp_trans,
    output logic [15:0]      trans_max,
    output logic             disp_upd,
    output logic             relay_warn,
    output logic             relay_err,
    output logic             relay_alarm,
    output logic             relay_maint,
    output logic             loop_force_2ma
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    oms_pkg::oms_state_t state_r, state_nxt;
    oms_pkg::oms_sub_t   sub_r;
    oms_pkg::oms_own_t   own_r;
    logic [1:0]  aux_s1_r, aux_s2_r, aux_s3_r, aux_val_r, aux_prev_r;
    logic        host_req_r;
    logic [1:0]  host_val_r;
    logic        test_r, was_test_r, wdog_r;
    logic [4:0]  cfg_r;
    logic [15:0] lowtx_r;
    logic [11:0] fsecs_r;
    logic [2:0]  usecs_r;
    logic [15:0] ramp_cnt_r;
    logic        lowtx_w, hour_w, wr_w, acc_w, map_w;
    logic [31:0] rdata_w;

    assign acc_w  = psel & penable & pready;
    assign wr_w   = acc_w & pwrite;
    assign lowtx_w = det_level < lowtx_r;
    assign hour_w = fsecs_r >= 12'(FAULT_SECS);
    assign map_w  = paddr == `OMS_CTRL_OFS  || paddr == `OMS_CFG_OFS ||
                    paddr == `OMS_LOWTX_OFS || paddr == `OMS_STATUS_OFS ||
                    paddr == `OMS_DISP_OFS;

    ////////////////////////////////////////////////////////////////////
    // APB: answer in the first access cycle, data ready from setup
    always_comb begin
        rdata_w = 32'h0;
        case (paddr)
            `OMS_CTRL_OFS: begin
                rdata_w[`OMS_CTRL_MODE_HI:`OMS_CTRL_MODE_LO] = host_val_r;
                rdata_w[`OMS_CTRL_TEST] = test_r;
            end
            `OMS_CFG_OFS:   rdata_w[4:0]  = cfg_r;
            `OMS_LOWTX_OFS: rdata_w[15:0] = lowtx_r;
            `OMS_STATUS_OFS: begin
                rdata_w[`OMS_ST_TOP +: 2]   = top_mode;
                rdata_w[`OMS_ST_SUB +: 2]   = sub_r;
                rdata_w[`OMS_ST_OWN +: 2]   = own_r;
                rdata_w[`OMS_ST_CAUSE]      = cause_wdog;
                rdata_w[`OMS_ST_WARN]       = warn_cond | lowtx_w;
                rdata_w[`OMS_ST_ERR]        = err_cond;
                rdata_w[`OMS_ST_LOWTX]      = lowtx_w;
                rdata_w[`OMS_ST_FCODE +: 4] = fault_nature;
                rdata_w[`OMS_ST_LPWR +: 8]  = laser_pwr;
            end
            `OMS_DISP_OFS:  rdata_w = {disp_trans, disp_conc};
            default:        rdata_w = 32'h0;
        endcase
    end

    // Ready, error and data all registered from the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~map_w;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_w : 32'h0;
        end
    end

    // Writable registers; a CTRL write is also a host mode request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r      <= `OMS_CFG_RST;
            lowtx_r    <= `OMS_LOWTX_RST;
            test_r     <= 1'b0;
            host_val_r <= 2'h0;
            host_req_r <= 1'b0;
        end else begin
            host_req_r <= 1'b0;
            if (wr_w && paddr == `OMS_CTRL_OFS) begin
                host_val_r <= pwdata[`OMS_CTRL_MODE_HI:`OMS_CTRL_MODE_LO];
                host_req_r <= 1'b1;
                test_r     <= pwdata[`OMS_CTRL_TEST];
            end
            if (wr_w && paddr == `OMS_CFG_OFS)
                cfg_r <= pwdata[4:0];
            if (wr_w && paddr == `OMS_LOWTX_OFS)
                lowtx_r <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // External control inputs: three flops, accept when last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_s1_r   <= 2'h0;
            aux_s2_r   <= 2'h0;
            aux_s3_r   <= 2'h0;
            aux_val_r  <= 2'h0;
            aux_prev_r <= 2'h0;
        end else begin
            aux_s1_r   <= aux_mode;
            aux_s2_r   <= aux_s1_r;
            aux_s3_r   <= aux_s2_r;
            if (aux_s2_r == aux_s3_r)
                aux_val_r <= aux_s3_r;
            aux_prev_r <= aux_val_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Top-level sequencing; fault overrides the sequence, a watchdog restart overrides fault
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            oms_pkg::S_INIT:     state_nxt = oms_pkg::S_SELFTEST;
            oms_pkg::S_SELFTEST: begin
                if (selftest_done)
                    state_nxt = selftest_pass ? oms_pkg::S_WARM
                                              : oms_pkg::S_FAULT;
            end
            oms_pkg::S_WARM: begin
                if (laser_temp_ok && stab_fig < `OMS_STAB_LIMIT)
                    state_nxt = oms_pkg::S_RAMP;
            end
            oms_pkg::S_RAMP: begin
                if (laser_pwr == `OMS_LPWR_MAX)
                    state_nxt = oms_pkg::S_MEAS;
            end
            oms_pkg::S_MEAS:     state_nxt = oms_pkg::S_MEAS;
            oms_pkg::S_FAULT: begin
                if (!test_r && (was_test_r || hour_w))
                    state_nxt = oms_pkg::S_INIT;
            end
            default:             state_nxt = oms_pkg::S_INIT;
        endcase
        if (state_r != oms_pkg::S_FAULT && (severe_fail || test_r))
            state_nxt = oms_pkg::S_FAULT;
        if (wdog_evt)
            state_nxt = oms_pkg::S_INIT;
    end

    // One state register; the top mode is a registered map of it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_r <= oms_pkg::S_INIT;
        else
            state_r <= state_nxt;
    end

    // Start cause: power at reset, supervision on forced restarts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdog_r <= 1'b0;
        else if (wdog_evt || (state_r == oms_pkg::S_FAULT &&
                 state_nxt == oms_pkg::S_INIT && !was_test_r))
            wdog_r <= 1'b1;
    end

    // Sleep entered for a host test leaves when the test ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            was_test_r <= 1'b0;
        else if (state_nxt != oms_pkg::S_FAULT)
            was_test_r <= 1'b0;
        else if (test_r)
            was_test_r <= 1'b1;
    end

    // Restart timer counts seconds only while in fault
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fsecs_r <= 12'h0;
        else if (state_r != oms_pkg::S_FAULT)
            fsecs_r <= 12'h0;
        else if (tick_1s && !hour_w)
            fsecs_r <= fsecs_r + 12'h1;
    end

    // Gradual laser power-up, one step per RAMP_DIV clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_cnt_r <= 16'h0;
            laser_pwr  <= 8'h0;
        end else if (state_r == oms_pkg::S_RAMP ||
                     state_r == oms_pkg::S_MEAS) begin
            if (ramp_cnt_r >= 16'(RAMP_DIV - 1)) begin
                ramp_cnt_r <= 16'h0;
                if (laser_pwr != `OMS_LPWR_MAX)
                    laser_pwr <= laser_pwr + 8'h1;
            end else begin
                ramp_cnt_r <= ramp_cnt_r + 16'h1;
            end
        end else begin
            ramp_cnt_r <= 16'h0;
            laser_pwr  <= 8'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sub-mode arbitration with owner lock; host wins a tie
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_r <= oms_pkg::SUB_NORMAL;
            own_r <= oms_pkg::OWN_NONE;
        end else if (state_r != oms_pkg::S_MEAS) begin
            sub_r <= oms_pkg::SUB_NORMAL;
            own_r <= oms_pkg::OWN_NONE;
        end else if (sub_r == oms_pkg::SUB_NORMAL) begin
            if (host_req_r && host_val_r != 2'h0) begin
                sub_r <= oms_pkg::oms_sub_t'(host_val_r);
                own_r <= oms_pkg::OWN_HOST;
            end else if (aux_val_r != aux_prev_r &&
                         aux_val_r != 2'h0) begin
                sub_r <= oms_pkg::oms_sub_t'(aux_val_r);
                own_r <= oms_pkg::OWN_AUX;
            end
        end else if ((own_r == oms_pkg::OWN_HOST && host_req_r &&
                       host_val_r == 2'h0) ||
                      (own_r == oms_pkg::OWN_AUX &&
                       aux_val_r != aux_prev_r && aux_val_r == 2'h0)) begin
            sub_r <= oms_pkg::SUB_NORMAL;
            own_r <= oms_pkg::OWN_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Periodic display and loop refresh while measuring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usecs_r    <= 3'h0;
            disp_upd   <= 1'b0;
            disp_conc  <= 16'h0;
            disp_trans <= 16'h0;
        end else begin
            disp_upd <= 1'b0;
            if (state_r != oms_pkg::S_MEAS) begin
                usecs_r <= 3'h0;
            end else if (tick_1s) begin
                if (usecs_r + 3'h1 >=
                    cfg_r[`OMS_CFG_PER_HI:`OMS_CFG_PER_LO]) begin
                    usecs_r    <= 3'h0;
                    disp_upd   <= 1'b1;
                    disp_conc  <= avg_conc;
                    disp_trans <= det_level;
                end else begin
                    usecs_r <= usecs_r + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status outputs and display selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_mode     <= oms_pkg::TOP_START;
            sub_mode     <= oms_pkg::SUB_NORMAL;
            owner        <= oms_pkg::OWN_NONE;
            cause_wdog   <= 1'b0;
            measuring    <= 1'b0;
            selftest_go  <= 1'b0;
            stab_out     <= 16'h0;
            trans_max    <= 16'h0;
            fault_nature <= 4'h0;
            disp_kind    <= oms_pkg::DISP_START;
            msg_code     <= oms_pkg::MSG_POWER;
        end else begin
            top_mode <= state_r == oms_pkg::S_MEAS  ? oms_pkg::TOP_MEAS :
                        state_r == oms_pkg::S_FAULT ? oms_pkg::TOP_FAULT :
                                                      oms_pkg::TOP_START;
            sub_mode    <= sub_r;
            owner       <= own_r;
            cause_wdog  <= wdog_r;
            measuring   <= state_r == oms_pkg::S_MEAS;
            selftest_go <= state_r == oms_pkg::S_INIT;
            trans_max   <= TRANS_MAX;
            if (state_r == oms_pkg::S_WARM || state_r == oms_pkg::S_RAMP)
                stab_out <= stab_fig;
            if (state_r != oms_pkg::S_FAULT)
                fault_nature <= fault_code;
            if (state_r == oms_pkg::S_FAULT) begin
                disp_kind <= oms_pkg::DISP_OFF;
                msg_code  <= was_test_r ? oms_pkg::MSG_TEST
                                        : oms_pkg::MSG_FAULT;
            end else if (state_r != oms_pkg::S_MEAS) begin
                disp_kind <= oms_pkg::DISP_START;
                msg_code  <= wdog_r ? oms_pkg::MSG_WDOG
                                    : oms_pkg::MSG_POWER;
            end else if (err_cond) begin
                disp_kind <= oms_pkg::DISP_ERROR;
                msg_code  <= oms_pkg::MSG_ERR;
            end else begin
                disp_kind <= oms_pkg::DISP_CONC;
                msg_code  <= lowtx_w   ? oms_pkg::MSG_LOWTX :
                             warn_cond ? oms_pkg::MSG_WARN :
                                         oms_pkg::MSG_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Relays fail open: any doubt leaves warning and error released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_warn     <= 1'b0;
            relay_err      <= 1'b0;
            relay_alarm    <= 1'b0;
            relay_maint    <= 1'b0;
            loop_force_2ma <= 1'b0;
        end else begin
            relay_warn  <= state_r == oms_pkg::S_MEAS && !err_cond &&
                           !warn_cond && !lowtx_w;
            relay_err   <= state_r == oms_pkg::S_MEAS && !err_cond;
            relay_alarm <= state_r == oms_pkg::S_FAULT;
            relay_maint <= state_r == oms_pkg::S_MEAS &&
                           sub_r == oms_pkg::SUB_MAINT &&
                           cfg_r[`OMS_CFG_RLY3];
            loop_force_2ma <= cfg_r[`OMS_CFG_LOOP2] &&
                              (state_r == oms_pkg::S_FAULT ||
                               (state_r == oms_pkg::S_MEAS && err_cond));
        end
    end

endmodule : oms_supervisor

`default_nettype wire
